/* File: design/hsp_pkg.sv */
// Purpose: constants for the host serial port with strapped baud rate
// Assumes: 250 MHz core clock
// Notes: baud divisors are derived from the clock rate by expression
package hsp_pkg;
  localparam int unsigned CLK_HZ = 250000000;
  localparam int unsigned BAUD_00 = 115200;
  localparam int unsigned BAUD_01 = 9600;
  localparam int unsigned BAUD_10 = 19200;
  localparam int unsigned BAUD_11 = 38400;
  localparam int unsigned DIV_00 = CLK_HZ / BAUD_00;
  localparam int unsigned DIV_01 = CLK_HZ / BAUD_01;
  localparam int unsigned DIV_10 = CLK_HZ / BAUD_10;
  localparam int unsigned DIV_11 = CLK_HZ / BAUD_11;
  localparam int unsigned DIV_W = 15;
  localparam int unsigned DATA_BITS = 8;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [1:0] STRAP_RST = 2'h0;
  typedef enum logic [1:0] {HSP_IDLE, HSP_START, HSP_DATA, HSP_STOP} hsp_state_t;
endpackage

/* File: design/hsp_top.sv */
// Purpose: full-duplex 8N1 serial port with baud picked by two straps
// Assumes: straps are static around reset release; line pulled up outside
// Notes: no buffering; tx_ready_o low while a character is in flight
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - start, eight data, one stop, no parity
// - transmit and receive run independently, concurrently
// - rates 9600 to 115200 set by straps
// - send on serial out, receive on in
// - straps sampled once after reset, then held
// - straps 00,01,10,11 give 115200,9600,19200,38400
// - serial output open drain, pulls low only
module hsp_top
  import hsp_pkg::*;
(
  input wire logic clk_i, // 250 MHz core clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic baud_select_low_i, // strap, low bit
  input wire logic baud_select_high_i, // strap, high bit
  input wire logic rxd_i, // serial line from the microcontroller
  output logic txd_o, // open drain output level, always 0
  output logic txd_oe_o, // high while pulling the line low
  input wire logic [7:0] tx_data_i, // character to send
  input wire logic tx_valid_i, // send request
  output logic tx_ready_o, // transmitter idle
  output logic [7:0] rx_data_o, // last received character
  output logic rx_valid_o, // one-cycle pulse, character received
  output logic rx_frame_err_o, // one-cycle pulse with rx_valid_o, bad stop
  output logic [1:0] baud_sel_o // latched strap pair
);
  // picks the cycles per bit for a latched strap pair
  function automatic logic [DIV_W-1:0] bit_div(input logic [1:0] sel);
    logic [DIV_W-1:0] r;
    r = DIV_W'(DIV_00);
    case (sel)
      2'h1: r = DIV_W'(DIV_01);
      2'h2: r = DIV_W'(DIV_10);
      2'h3: r = DIV_W'(DIV_11);
      default: r = DIV_W'(DIV_00);
    endcase
    return r;
  endfunction

  // strap latch: first clock after release takes the pins, later edges hold
  logic [1:0] strap_q, strap_d;
  logic strap_done_q, strap_done_d;
  logic [DIV_W-1:0] div;
  always_comb begin
    strap_d = strap_q;
    strap_done_d = 1'b1;
    if (!strap_done_q) begin
      strap_d = {baud_select_high_i, baud_select_low_i};
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strap_q <= STRAP_RST;
      strap_done_q <= 1'b0;
    end else begin
      strap_q <= strap_d;
      strap_done_q <= strap_done_d;
    end
  end
  assign div = bit_div(strap_q);
  assign baud_sel_o = strap_q;

  // rx synchroniser: three stages, change taken when stages two and three agree
  logic [2:0] rx_sync_q, rx_sync_d;
  logic rx_line_q, rx_line_d;
  always_comb begin
    rx_sync_d = {rx_sync_q[1:0], rxd_i};
    rx_line_d = rx_line_q;
    if (rx_sync_q[1] == rx_sync_q[2]) begin
      rx_line_d = rx_sync_q[2];
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_sync_q <= 3'h7;
      rx_line_q <= 1'b1;
    end else begin
      rx_sync_q <= rx_sync_d;
      rx_line_q <= rx_line_d;
    end
  end

  // transmitter; runs beside the receiver with its own state
  hsp_state_t tx_st_q, tx_st_d;
  logic [DIV_W-1:0] tx_cnt_q, tx_cnt_d;
  logic [3:0] tx_bit_q, tx_bit_d;
  logic [7:0] tx_sh_q, tx_sh_d;
  logic tx_line_q, tx_line_d;
  logic tx_tick;
  assign tx_tick = (tx_cnt_q == div - DIV_W'(1));
  always_comb begin
    tx_st_d = tx_st_q;
    tx_cnt_d = tx_tick ? '0 : tx_cnt_q + DIV_W'(1);
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    tx_line_d = tx_line_q;
    case (tx_st_q)
      HSP_IDLE: begin
        tx_line_d = 1'b1;
        tx_cnt_d = '0;
        // no launch before the straps are latched, so the first bit has the right length
        if (tx_valid_i && strap_done_q) begin
          tx_sh_d = tx_data_i;
          tx_line_d = 1'b0;
          tx_st_d = HSP_START;
        end
      end
      HSP_START: begin
        if (tx_tick) begin
          tx_line_d = tx_sh_q[0];
          tx_sh_d = {1'b0, tx_sh_q[7:1]};
          tx_bit_d = BIT_CNT_RST;
          tx_st_d = HSP_DATA;
        end
      end
      HSP_DATA: begin
        if (tx_tick) begin
          if (tx_bit_q == 4'(DATA_BITS - 1)) begin
            tx_line_d = 1'b1;
            tx_st_d = HSP_STOP;
          end else begin
            tx_line_d = tx_sh_q[0];
            tx_sh_d = {1'b0, tx_sh_q[7:1]};
            tx_bit_d = tx_bit_q + 4'h1;
          end
        end
      end
      default: begin
        if (tx_tick) begin
          tx_st_d = HSP_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_st_q <= HSP_IDLE;
      tx_cnt_q <= '0;
      tx_bit_q <= BIT_CNT_RST;
      tx_sh_q <= 8'h00;
      tx_line_q <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      tx_cnt_q <= tx_cnt_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
      tx_line_q <= tx_line_d;
    end
  end
  // open drain: the level is always low, only the enable moves
  assign txd_o = 1'b0;
  assign txd_oe_o = ~tx_line_q;
  assign tx_ready_o = (tx_st_q == HSP_IDLE) && strap_done_q;

  // receiver: samples mid-bit; a start glitch shorter than half a bit is dropped
  hsp_state_t rx_st_q, rx_st_d;
  logic [DIV_W-1:0] rx_cnt_q, rx_cnt_d;
  logic [3:0] rx_bit_q, rx_bit_d;
  logic [7:0] rx_sh_q, rx_sh_d, rx_data_q, rx_data_d;
  logic rx_vld_q, rx_vld_d, rx_err_q, rx_err_d;
  logic rx_tick, rx_half;
  assign rx_tick = (rx_cnt_q == div - DIV_W'(1));
  assign rx_half = (rx_cnt_q == (div >> 1));
  always_comb begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_tick ? '0 : rx_cnt_q + DIV_W'(1);
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_data_d = rx_data_q;
    rx_vld_d = 1'b0;
    rx_err_d = 1'b0;
    case (rx_st_q)
      HSP_IDLE: begin
        rx_cnt_d = '0;
        if (!rx_line_q && strap_done_q) begin
          rx_st_d = HSP_START;
        end
      end
      HSP_START: begin
        if (rx_half) begin
          if (rx_line_q) begin
            rx_st_d = HSP_IDLE;
          end else begin
            rx_cnt_d = '0;
            rx_bit_d = BIT_CNT_RST;
            rx_st_d = HSP_DATA;
          end
        end
      end
      HSP_DATA: begin
        if (rx_tick) begin
          rx_sh_d = {rx_line_q, rx_sh_q[7:1]};
          rx_bit_d = rx_bit_q + 4'h1;
          if (rx_bit_q == 4'(DATA_BITS - 1)) begin
            rx_st_d = HSP_STOP;
          end
        end
      end
      default: begin
        if (rx_tick) begin
          rx_data_d = rx_sh_q;
          rx_vld_d = 1'b1;
          rx_err_d = ~rx_line_q;
          rx_st_d = HSP_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_st_q <= HSP_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= BIT_CNT_RST;
      rx_sh_q <= 8'h00;
      rx_data_q <= 8'h00;
      rx_vld_q <= 1'b0;
      rx_err_q <= 1'b0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_data_q <= rx_data_d;
      rx_vld_q <= rx_vld_d;
      rx_err_q <= rx_err_d;
    end
  end
  assign rx_data_o = rx_data_q;
  assign rx_valid_o = rx_vld_q;
  assign rx_frame_err_o = rx_err_q;

  // checks
  sequence s_tx_launch;
    tx_st_q == HSP_IDLE && tx_valid_i && tx_ready_o;
  endsequence
  chk_strap_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    strap_done_q |=> $stable(strap_q)) else $error("strap changed after latch");
  chk_div_map: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    div == ((strap_q == 2'h0) ? DIV_W'(DIV_00) : (strap_q == 2'h1) ? DIV_W'(DIV_01) :
      (strap_q == 2'h2) ? DIV_W'(DIV_10) : DIV_W'(DIV_11))) else $error("divisor wrong");
  chk_od_low: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    txd_o == 1'b0 && (!txd_oe_o || tx_st_q == HSP_START || tx_st_q == HSP_DATA))
    else $error("open drain pulled low outside start or data");
  chk_tx_start: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_tx_launch |=> txd_oe_o) else $error("start bit not low");
  chk_idle_high: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    tx_st_q == HSP_IDLE && !$past(tx_valid_i) |-> !txd_oe_o) else $error("idle not high");
  chk_stop_high: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    tx_st_q == HSP_STOP |-> !txd_oe_o) else $error("stop bit not high");
  chk_tx_bits: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    tx_st_q == HSP_DATA |-> tx_bit_q < 4'h8) else $error("too many data bits");
  chk_tx_first: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (tx_st_q == HSP_START && tx_tick) |=> txd_oe_o == !$past(tx_sh_q[0]))
    else $error("lsb not first");
  chk_rx_pulse: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    rx_valid_o |=> !rx_valid_o) else $error("rx valid not one cycle");
endmodule
`default_nettype wire

/* File: bench/hsp_host_model.sv */
// Purpose: microcontroller-side uart model facing the host serial port
// Assumes: port strapped to 115200, so one bit is DIV_00 clocks
// Notes: times bits by the core clock; stop level can be forced low
`timescale 1ns/1ps
`default_nettype none
module hsp_host_model
  import hsp_pkg::*;
(
  input wire logic clk_i, // core clock, used as the bit timer
  input wire logic line_i, // port output as seen past the pull-up
  output logic rxd_o, // our push-pull line toward the port
  output logic [7:0] got_o, // last character decoded
  output logic got_stop_o // stop level of that character
);
  int unsigned got_n = 0;
  initial rxd_o = 1'b1;
  // decode from mid-bit, so a wrong rate or order corrupts the byte
  always begin
    @(negedge line_i);
    repeat (DIV_00 / 2) @(negedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (DIV_00) @(negedge clk_i);
      got_o[i] = line_i;
    end
    repeat (DIV_00) @(negedge clk_i);
    got_stop_o = line_i;
    got_n++;
  end
  // send one frame; a low stop is only used to provoke a frame error
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_o = f[i];
      repeat (DIV_00) @(negedge clk_i);
    end
    rxd_o = 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// Purpose: self-checking bench for the host serial port
// Assumes: traffic only at 115200 to keep the run short
// Notes: other strap codes checked through the latched pair only
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hsp_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic sel_lo = 1'b0;
  logic sel_hi = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic rxd, txd, txd_oe, tx_ready, rx_valid, rx_err;
  logic [7:0] rx_data, last_rx;
  logic [1:0] baud_sel;
  logic last_err;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;
  int rx_n = 0;
  always #2 clk = ~clk;
  hsp_top uut (.clk_i(clk), .arst_n_i(arst_n), .baud_select_low_i(sel_lo),
    .baud_select_high_i(sel_hi), .rxd_i(rxd), .txd_o(txd), .txd_oe_o(txd_oe),
    .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
    .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_frame_err_o(rx_err),
    .baud_sel_o(baud_sel));
  // line level is the pull-up unless the port pulls low
  hsp_host_model host (.clk_i(clk), .line_i(!txd_oe), .rxd_o(rxd), .got_o(),
    .got_stop_o());
  // capture the one-cycle receive pulse mid-cycle, where it has settled
  always @(negedge clk) begin
    cycles++;
    if (rx_valid === 1'b1) begin
      last_rx = rx_data;
      last_err = rx_err;
      rx_n++;
    end
    if (cycles == 100000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic do_reset(input logic [1:0] s);
    {sel_hi, sel_lo} = s;
    arst_n = 1'b0;
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  // every strap code latched, later strap moves ignored
  task automatic straps_test();
    for (int s = 0; s < 4; s++) begin
      do_reset(s[1:0]);
      {sel_hi, sel_lo} = ~s[1:0];
      repeat (3) @(negedge clk);
      check({6'h00, baud_sel}, s[7:0]);
    end
  endtask
  // wait for both the host and the port to report a character
  task automatic wait_both(input int g0, input int r0);
    for (int k = 0; k < 30000 && (host.got_n == g0 || rx_n == r0); k++)
      @(negedge clk);
  endtask
  // send and receive at once, then a frame with a low stop bit
  task automatic duplex_test();
    int g0, r0;
    do_reset(2'h0);
    check({txd, txd_oe, tx_ready}, 8'h01);
    g0 = host.got_n;
    r0 = rx_n;
    tx_data = 8'hA5;
    tx_valid = 1'b1;
    @(negedge clk);
    tx_valid = 1'b0;
    @(negedge clk);
    check({txd, txd_oe, tx_ready}, 8'h02);
    host.send(8'h3C, 1'b1);
    wait_both(g0, r0);
    check(host.got_o, 8'hA5);
    check({7'h00, host.got_stop_o}, 8'h01);
    check(last_rx, 8'h3C);
    check({7'h00, last_err}, 8'h00);
    r0 = rx_n;
    host.send(8'h81, 1'b0);
    wait_both(-1, r0);
    check(last_rx, 8'h81);
    check({7'h00, last_err}, 8'h01);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    straps_test();
    duplex_test();
    finish_test();
  end
endmodule
`default_nettype wire
